/* adc_sfr_pkg.sv */
// package for the converter register block: register map, field positions,
// state codes and timing counts.
// assumes a 25 MHz system clock; times are kept in ns and converted here.
package adc_sfr_pkg;

  // register addresses on the special function register bus
  localparam logic [7:0] ADDR_RES_FLAGS = 8'hd1; // converter_resolution_and_flags
  localparam logic [7:0] ADDR_MODE_TIMING = 8'hd2; // converter_mode_and_timing
  localparam logic [7:0] ADDR_PWR_CH_REF = 8'hd3; // converter_power_channel_reference
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hd4; // conversion_result_high
  localparam logic [7:0] ADDR_RESULT_LOW = 8'hd5; // conversion_result_low
  localparam logic [7:0] RESET_VALUE = 8'h00; // every register resets here

  // field positions, power/channel/reference register
  localparam int POS_PWRUP = 7;
  localparam int POS_BUSY = 6;
  localparam int POS_CHSEL_LO = 2;
  localparam int POS_REFSEL_LO = 0;
  // field positions, mode/timing register
  localparam int POS_DIFF_LO = 6;
  localparam int POS_CONT = 5;
  localparam int POS_RATE_LO = 2;
  localparam int POS_TACQ_LO = 0;
  // field positions, resolution/flags register
  localparam int POS_RESOL_LO = 6;
  localparam int POS_RLJUST = 5;
  localparam int POS_UFLOW = 4;
  localparam int POS_OFLOW = 3;
  localparam int POS_RANGE = 2;

  // timing, in ns, and cycle counts at the system clock rate
  localparam int CLK_MHZ = 25;
  localparam int T_START_NS = 250; // four cycles of the 16 MHz converter clock
  localparam int T_WUP_OFF_NS = 15000; // wakeup from full power-down
  localparam int T_WUP_SBY_NS = 600; // wakeup from standby
  localparam int T_ACQ0_NS = 750;
  localparam int T_ACQ1_NS = 3000;
  localparam int T_ACQ2_NS = 12000;
  localparam int T_ACQ3_NS = 36000;
  localparam int T_CONV0_NS = 1700;
  localparam int T_CONV1_NS = 1900;
  localparam int T_CONV2_NS = 2100;
  localparam int T_CONV3_NS = 2300;
  localparam int T_PD1_NS = 6000; // standby hold before power-down
  localparam int T_PD2_NS = 24000;
  localparam int T_RATE8K_NS = 125000;
  localparam int T_RATE16K_NS = 62500;
  localparam logic [15:0] START_CYC = 16'((T_START_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] WUP_OFF_CYC = 16'((T_WUP_OFF_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] WUP_SBY_CYC = 16'((T_WUP_SBY_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] ACQ0_CYC = 16'((T_ACQ0_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] ACQ1_CYC = 16'((T_ACQ1_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] ACQ2_CYC = 16'((T_ACQ2_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] ACQ3_CYC = 16'((T_ACQ3_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] CONV0_CYC = 16'((T_CONV0_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] CONV1_CYC = 16'((T_CONV1_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] CONV2_CYC = 16'((T_CONV2_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] CONV3_CYC = 16'((T_CONV3_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] PD1_CYC = 16'((T_PD1_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] PD2_CYC = 16'((T_PD2_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] RATE8K_CYC = 16'((T_RATE8K_NS * CLK_MHZ) / 1000);
  localparam logic [15:0] RATE16K_CYC = 16'((T_RATE16K_NS * CLK_MHZ) / 1000);

  // sequencer states
  typedef enum logic [2:0] {
    ST_OFF = 3'b000, // powered down
    ST_START = 3'b001, // start delay before busy
    ST_WAKE = 3'b010, // analog wakeup
    ST_ACQ = 3'b011, // sampling capacitor on the input
    ST_CONV = 3'b100, // successive approximation
    ST_STBY = 3'b101, // standby after a single step
    ST_WAIT = 3'b110 // powered down, waiting for the next continuous sample
  } seq_state_t;

  // one special function register bus cycle
  typedef struct packed {
    logic [7:0] addr; // register address
    logic wr; // write strobe, one cycle
    logic [7:0] wdata; // write data
  } sfr_req_t;

  // settings handed to the analog core
  typedef struct packed {
    logic [3:0] channel; // 0..13 pins, 14/15 internal supply fractions
    logic [1:0] reference; // bandgap, supply, analog_input_3, analog_input_9
    logic [1:0] input_mode; // single ended or differential
    logic [1:0] resolution; // 6, 8, 10, 12 bits
  } analog_cfg_t;

endpackage

/* adc_sfr_control.sv */
// converter register block: five special function registers, the conversion
// sequencer and result justification for a successive-approximation core.
// assumes the analog core holds a 12-bit msb-aligned sample on
// core_sample_in when the conversion phase ends, and a synchronous bus.
//
// Summary of operation
// [RL1] power bit low powers down, high enables
// [RL2] busy flag set while a conversion runs
// [RL3] reference field selects bandgap, supply, external inputs
// [RL4] input mode: single ended or two differential
// [RL5] mode bit selects single step or continuous
// [RL6] rate field sets continuous sampling rate
// [RL7] rate field sets standby hold in single step
// [RL8] acquisition field sets sampling window length
// [RL9] justify bit picks left or right alignment
// [RL10] resolution field gives 6, 8, 10, 12 bits
// [RL11] underflow flag when result all zeroes
// [RL12] overflow flag when result all ones
// [RL13] range flag is underflow or overflow
// [RL14] high result register gives upper byte
// [RL15] low result register gives lower byte
// [RL16] all five registers reset to zero
// [RL17] channel field selects pins or supply fractions
// [RL18] only power register writes start conversions
// [RL19] busy rises after start delay; done interrupt
// [RL20] continuous mode restarts automatically, powered down between
// [RL21] writes to read-only bits are ignored
`timescale 1ns/1ps
`default_nettype none

module adc_sfr_control #(
  parameter logic [15:0] RATE2K_CYC = 16'd12500, // 2 ksps period in cycles
  parameter logic [15:0] RATE4K_CYC = 16'd6250 // 4 ksps period in cycles
) (
  input wire logic clk_sys_in, // 25 MHz system clock
  input wire logic rst_n_in, // asynchronous reset, active low
  input wire adc_sfr_pkg::sfr_req_t sfr_req_in, // bus address, strobe, data
  output logic [7:0] sfr_rdata_out, // read data, one cycle after address
  input wire logic [11:0] core_sample_in, // analog core sample, msb aligned
  output adc_sfr_pkg::analog_cfg_t analog_cfg_out, // settings to the core
  output logic pins_analog_out, // selected pins configured as analog
  output logic core_power_out, // analog core fully powered
  output logic core_standby_out, // analog core in standby
  output logic sample_switch_out, // sampling capacitor connected
  output logic convert_out, // conversion phase active
  output logic conversion_done_interrupt_out // end-of-conversion pulse
);
  import adc_sfr_pkg::*;

  // software-written fields
  logic pwrup; // power control
  logic [3:0] chsel; // input channel
  logic [1:0] refsel; // reference select
  logic [1:0] diffm; // input mode
  logic cont; // continuous mode
  logic [2:0] rate; // rate or power-down delay
  logic [1:0] tacq; // acquisition time code
  logic [1:0] resol; // resolution code
  logic rljust; // right justify
  // hardware-owned state
  logic uflow; // result all zeroes
  logic oflow; // result all ones
  logic [15:0] result_word; // justified result, high and low bytes
  logic [11:0] conv_result; // right-aligned raw result, for checks
  seq_state_t state; // sequencer state
  seq_state_t next_state; // sequencer next state
  logic [15:0] timer; // phase countdown
  logic [15:0] next_timer; // phase countdown next value
  logic [15:0] rate_cnt; // continuous sample period countdown
  logic from_standby; // short wakeup: start came from standby or a busy phase
  logic done; // end of conversion this cycle
  logic busy; // conversion in progress

  // decoded bus strobes
  logic wr_pcr, wr_mode, wr_res; // writes per configuration register
  logic start_wr; // write that starts a conversion
  assign wr_pcr = sfr_req_in.wr && (sfr_req_in.addr == ADDR_PWR_CH_REF);
  assign wr_mode = sfr_req_in.wr && (sfr_req_in.addr == ADDR_MODE_TIMING);
  assign wr_res = sfr_req_in.wr && (sfr_req_in.addr == ADDR_RES_FLAGS);
  // only the power register starts, and only with the power bit written high
  assign start_wr = wr_pcr && sfr_req_in.wdata[POS_PWRUP]; // [RL18]

  // busy spans wakeup, acquisition and conversion
  assign busy = (state == ST_WAKE) || (state == ST_ACQ) || (state == ST_CONV); // [RL2]

  // power/channel/reference register; busy is never stored from the bus
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwrup <= 1'b0; // [RL16]
      chsel <= 4'h0;
      refsel <= 2'h0;
    end else if (wr_pcr) begin
      pwrup <= sfr_req_in.wdata[POS_PWRUP]; // [RL1]
      chsel <= sfr_req_in.wdata[POS_CHSEL_LO +: 4]; // [RL17]
      refsel <= sfr_req_in.wdata[POS_REFSEL_LO +: 2]; // [RL3] [RL21]
    end
  end

  // mode/timing register, all bits writable
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      diffm <= 2'h0; // [RL16]
      cont <= 1'b0;
      rate <= 3'h0;
      tacq <= 2'h0;
    end else if (wr_mode) begin
      diffm <= sfr_req_in.wdata[POS_DIFF_LO +: 2]; // [RL4]
      cont <= sfr_req_in.wdata[POS_CONT]; // [RL5]
      rate <= sfr_req_in.wdata[POS_RATE_LO +: 3];
      tacq <= sfr_req_in.wdata[POS_TACQ_LO +: 2]; // [RL8]
    end
  end

  // resolution/flags register: flag and unused bits stay hardware-owned
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      resol <= 2'h0; // [RL16]
      rljust <= 1'b0;
    end else if (wr_res) begin
      resol <= sfr_req_in.wdata[POS_RESOL_LO +: 2]; // [RL10]
      rljust <= sfr_req_in.wdata[POS_RLJUST]; // [RL9] [RL21]
    end
  end

  // phase lengths picked from the current settings
  logic [15:0] acq_len, conv_len, pd_len, period_len; // per-phase cycle counts
  always_comb begin
    unique case (tacq)
      2'b00: acq_len = ACQ0_CYC; // [RL8]
      2'b01: acq_len = ACQ1_CYC;
      2'b10: acq_len = ACQ2_CYC;
      2'b11: acq_len = ACQ3_CYC;
    endcase
    unique case (resol)
      2'b00: conv_len = CONV0_CYC; // longer for more bits
      2'b01: conv_len = CONV1_CYC;
      2'b10: conv_len = CONV2_CYC;
      2'b11: conv_len = CONV3_CYC;
    endcase
    // reserved rate codes fall back to the shortest behaviour
    unique case (rate)
      3'b001: pd_len = PD1_CYC; // [RL7]
      3'b010: pd_len = PD2_CYC;
      default: pd_len = 16'h0000;
    endcase
    unique case (rate)
      3'b000: period_len = RATE2K_CYC; // [RL6]
      3'b001: period_len = RATE4K_CYC;
      3'b010: period_len = RATE8K_CYC;
      default: period_len = RATE16K_CYC;
    endcase
  end

  // sequencer next state; a start write wins over every phase and aborts it
  always_comb begin
    next_state = state;
    next_timer = (timer == 16'h0000) ? 16'h0000 : timer - 16'h0001;
    if (!pwrup || wr_pcr) begin // a power-low write stops at once
      next_state = ST_OFF; // [RL1]
      next_timer = 16'h0000;
    end
    if (start_wr) begin
      next_state = ST_START; // [RL18]
      next_timer = START_CYC - 16'h0001;
    end else if (pwrup && !wr_pcr) begin
      unique case (state)
        ST_OFF: begin
          next_state = ST_OFF; // waits for a start write
        end
        ST_START: begin
          if (timer == 16'h0000) begin
            next_state = ST_WAKE; // [RL19]
            next_timer = (from_standby ? WUP_SBY_CYC : WUP_OFF_CYC) - 16'h0001;
          end
        end
        ST_WAKE: begin
          if (timer == 16'h0000) begin
            next_state = ST_ACQ;
            next_timer = acq_len - 16'h0001;
          end
        end
        ST_ACQ: begin
          if (timer == 16'h0000) begin
            next_state = ST_CONV;
            next_timer = conv_len - 16'h0001;
          end
        end
        ST_CONV: begin
          if (timer == 16'h0000) begin
            if (cont) begin
              next_state = ST_WAIT; // [RL20]
            end else if (rate == 3'b011) begin
              next_state = ST_STBY; // held while rate stays 3'b011 and no power register write comes
            end else if (pd_len != 16'h0000) begin
              next_state = ST_STBY; // [RL7]
              next_timer = pd_len - 16'h0001;
            end else begin
              next_state = ST_OFF;
            end
          end
        end
        ST_STBY: begin
          if (timer == 16'h0000 && rate != 3'b011) begin
            next_state = ST_OFF;
          end
        end
        ST_WAIT: begin
          if (rate_cnt == 16'h0000) begin
            next_state = ST_START; // [RL20]
            next_timer = START_CYC - 16'h0001;
          end
        end
        default: begin
          next_state = ST_OFF; // unused code recovers to power-down
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_OFF;
      timer <= 16'h0000;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // wakeup length depends on where the start came from; sampled at entry
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      from_standby <= 1'b0;
    end else if (next_state == ST_START && state != ST_START) begin
      from_standby <= (state == ST_STBY) || busy;
    end
  end

  // continuous sample period, restarted at each start so the rate holds;
  // if a conversion outlasts the period the next one follows at once
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rate_cnt <= 16'h0000;
    end else if (next_state == ST_START && state != ST_START) begin
      rate_cnt <= period_len - 16'h0001; // [RL6]
    end else if (rate_cnt != 16'h0000) begin
      rate_cnt <= rate_cnt - 16'h0001;
    end
  end

  // end of conversion, lost if aborted by a write or power-down that cycle
  assign done = (state == ST_CONV) && (timer == 16'h0000) && pwrup && !wr_pcr;

  // result truncation and justification
  logic [11:0] res_mask; // kept bits of the msb-aligned sample
  logic [3:0] res_shift; // shift to right-align
  logic [11:0] masked; // sample cut to resolution
  always_comb begin
    unique case (resol)
      2'b00: begin
        res_mask = 12'hfc0; // [RL10]
        res_shift = 4'h6;
      end
      2'b01: begin
        res_mask = 12'hff0;
        res_shift = 4'h4;
      end
      2'b10: begin
        res_mask = 12'hffc;
        res_shift = 4'h2;
      end
      2'b11: begin
        res_mask = 12'hfff;
        res_shift = 4'h0;
      end
    endcase
    masked = core_sample_in & res_mask;
  end

  // result and range flags update only at end of conversion
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_word <= 16'h0000; // [RL16]
      conv_result <= 12'h000;
      uflow <= 1'b0;
      oflow <= 1'b0;
    end else if (done) begin
      conv_result <= masked >> res_shift;
      uflow <= (masked == 12'h000); // [RL11]
      oflow <= (masked == res_mask); // [RL12]
      if (rljust) begin
        result_word <= {4'h0, masked >> res_shift}; // [RL9]
      end else begin
        result_word <= {masked, 4'h0}; // left starts at high bit 7
      end
    end
  end

  // one-cycle interrupt at each end of conversion
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conversion_done_interrupt_out <= 1'b0;
    end else begin
      conversion_done_interrupt_out <= done; // [RL19]
    end
  end

  // registered read mux; unmapped addresses read zero
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sfr_rdata_out <= RESET_VALUE;
    end else begin
      unique case (sfr_req_in.addr)
        ADDR_PWR_CH_REF: sfr_rdata_out <= {pwrup, busy, chsel, refsel}; // [RL2]
        ADDR_MODE_TIMING: sfr_rdata_out <= {diffm, cont, rate, tacq};
        ADDR_RES_FLAGS: sfr_rdata_out <= {resol, rljust, uflow, oflow,
                                          uflow | oflow, 2'b00}; // [RL13]
        ADDR_RESULT_HIGH: sfr_rdata_out <= result_word[15:8]; // [RL14]
        ADDR_RESULT_LOW: sfr_rdata_out <= result_word[7:0]; // [RL15]
        default: sfr_rdata_out <= 8'h00;
      endcase
    end
  end

  // analog control; settings pass through so a mid-run change takes effect
  assign analog_cfg_out = '{channel: chsel, reference: refsel,
                            input_mode: diffm, resolution: resol}; // [RL17] [RL3] [RL4]
  assign pins_analog_out = pwrup; // [RL1]
  assign core_power_out = busy || (state == ST_START);
  assign core_standby_out = (state == ST_STBY);
  assign sample_switch_out = (state == ST_ACQ);
  assign convert_out = (state == ST_CONV);

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  busy_after_start_a: assert property ($rose(busy) |-> $past(state) == ST_START) // [RL19]
    else $error("busy rose without start delay");
  start_delay_a: assert property (start_wr ##1 (!wr_pcr && pwrup) [*7] |=> busy) // [RL19]
    else $error("busy not set after start delay");
  power_off_a: assert property (!pwrup |-> !busy && !core_power_out) // [RL1]
    else $error("converter active while powered down");
  cfg_no_start_a: assert property ((wr_mode || wr_res) && state == ST_OFF && !wr_pcr
    |=> state == ST_OFF) // [RL18]
    else $error("mode write started a conversion");
  done_clears_busy_a: assert property (conversion_done_interrupt_out |-> !busy && $past(busy)) // [RL2]
    else $error("busy not cleared at result");
  right_just_a: assert property (conversion_done_interrupt_out && rljust && resol == 2'b01
    |-> result_word[15:8] == 8'h00 && result_word[7:0] == conv_result[7:0]) // [RL9]
    else $error("right justified result misplaced");
  left_just_a: assert property (conversion_done_interrupt_out && !rljust && resol == 2'b10
    |-> result_word[5:0] == 6'h00 && result_word[15:6] == conv_result[9:0]) // [RL10]
    else $error("left justified result misplaced");
  under_flag_a: assert property (conversion_done_interrupt_out
    |-> uflow == (result_word == 16'h0000)) // [RL11]
    else $error("underflow flag wrong");
  range_read_a: assert property (sfr_req_in.addr == ADDR_RES_FLAGS
    |=> sfr_rdata_out[2] == (sfr_rdata_out[4] | sfr_rdata_out[3])) // [RL13]
    else $error("range flag not or of flags");
  ro_write_a: assert property (wr_res && !done |=> $stable(uflow) && $stable(oflow)) // [RL21]
    else $error("read-only flags changed by write");

  single_cov: cover property (start_wr ##[1:1000] conversion_done_interrupt_out);
  cont_cov: cover property (state == ST_WAIT ##[1:1000] state == ST_START);
  abort_cov: cover property (busy && start_wr);
  standby_cov: cover property (state == ST_STBY ##1 state == ST_START);

endmodule

`default_nettype wire

/* adc_core_model.sv */
// behavioural analog core facing the converter register block.
// assumes the block samples core_sample_in only while convert_out is high.
`timescale 1ns/1ps
`default_nettype none

module adc_core_model (
  input wire logic clk_in, // system clock
  input wire logic convert_in, // conversion phase from the block
  input wire logic [11:0] level_in, // value the selected pin carries
  output logic [11:0] sample_out // sample toward the block
);
  logic [11:0] junk; // flips between two codes every cycle

  // outside conversion the output is garbage, so a block that samples
  // at the wrong moment picks up a wrong code instead of a lucky match
  initial junk = 12'h5a5;
  always @(posedge clk_in) begin
    junk <= ~junk + 12'h001;
  end
  assign sample_out = convert_in ? level_in : junk;
endmodule

`default_nettype wire

/* adc_sfr_control_tb_top.sv */
// bench for the converter register block: a table of conversions, then
// reset, bus, abort, standby, continuous and power-down cases.
// assumes inputs change on the falling edge and the core model answers.
`timescale 1ns/1ps
`default_nettype none

module adc_sfr_control_tb_top;
  import adc_sfr_pkg::*;
  logic clk_sys_in = 1'b0; // system clock
  logic rst_n_in = 1'b0; // reset, active low
  sfr_req_t req = '0; // bus request
  logic [7:0] rdata; // bus read data
  logic [11:0] smp; // core sample
  logic [11:0] level = 12'h000; // pin level for the model
  analog_cfg_t cfg; // settings to the core
  logic pins, pwr, sby, sw, conv, irq; // status outputs
  int fails = 0; // mismatches
  int check_count = 0; // comparisons
  int n; // cycles counted by the last wait
  logic [7:0] rv; // last read value
  logic [23:0] e; // expected flags and result word
  int acq [4] = '{19, 75, 300, 900}; // acquisition cycles by code
  int cv [4] = '{43, 48, 53, 58}; // conversion cycles by resolution
  typedef struct packed {logic [7:0] d1, d2, d3; logic [11:0] s;} row_t;
  // resolution/justify, mode, power/channel/reference, sample
  row_t rows [4] = '{'{8'h00, 8'h00, 8'h80, 12'h000}, '{8'h60, 8'h41, 8'hb6, 12'hff0},
    '{8'h80, 8'h82, 8'hb9, 12'ha5c}, '{8'he0, 8'h03, 8'hbf, 12'h123}};

  always #20 clk_sys_in = ~clk_sys_in;

  adc_sfr_control #(.RATE2K_CYC(16'd200), .RATE4K_CYC(16'd100)) u_dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sfr_req_in(req),
    .sfr_rdata_out(rdata), .core_sample_in(smp), .analog_cfg_out(cfg),
    .pins_analog_out(pins), .core_power_out(pwr), .core_standby_out(sby),
    .sample_switch_out(sw), .convert_out(conv), .conversion_done_interrupt_out(irq));

  adc_core_model u_core (.clk_in(clk_sys_in), .convert_in(conv), .level_in(level),
    .sample_out(smp));

  // expected flag byte and justified word, worked out independently
  function automatic logic [23:0] expect_of(input logic [7:0] d1, input logic [11:0] s);
    int nb;
    logic [11:0] r;
    logic z, o;
    nb = 6 + 2 * int'(d1[7:6]);
    r = s >> (12 - nb);
    z = (r == 12'h000);
    o = (r == 12'((1 << nb) - 1));
    return {d1[7:5], z, o, z | o, 2'b00, d1[5] ? 16'(r) : 16'(r) << (16 - nb)};
  endfunction

  task automatic results();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe, held across exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    req = '{a, 1'b1, d};
    @(negedge clk_sys_in);
    req.wr = 1'b0;
  endtask

  // read data lands on the same edge that samples the address
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys_in);
    req.addr = a;
    @(negedge clk_sys_in);
    rv = rdata;
  endtask

  // cycles from the last write edge to the done pulse, bounded
  task automatic wait_irq();
    n = 0;
    do begin
      @(negedge clk_sys_in);
      n++;
    end while (irq !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      fails++;
      results();
    end
  endtask

  // counts done pulses over a stretch where none may come
  task automatic quiet(input int c);
    int k;
    k = 0;
    repeat (c) begin
      @(negedge clk_sys_in);
      if (irq === 1'b1) k++;
    end
    chk(16'(k), 16'h0000);
  endtask

  initial begin
    repeat (3) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    // every register reads zero, the unmapped address too
    for (int a = 'hd0; a <= 'hd5; a++) begin
      rd(8'(a));
      chk(16'(rv), 16'h0000);
    end
    // table: low bits of the flag register are written as ones and ignored
    foreach (rows[i]) begin
      level = rows[i].s;
      e = expect_of(rows[i].d1, rows[i].s);
      wr(ADDR_RES_FLAGS, rows[i].d1 | 8'h1f);
      wr(ADDR_MODE_TIMING, rows[i].d2);
      wr(ADDR_PWR_CH_REF, rows[i].d3);
      chk(16'(cfg), 16'({rows[i].d3[5:0], rows[i].d2[7:6], rows[i].d1[7:6]}));
      chk(16'(pins), 16'h0001);
      wait_irq();
      chk(16'(n), 16'(382 + acq[rows[i].d2[1:0]] + cv[rows[i].d1[7:6]]));
      rd(ADDR_RESULT_HIGH);
      chk(16'(rv), 16'(e[15:8]));
      rd(ADDR_RESULT_LOW);
      chk(16'(rv), 16'(e[7:0]));
      rd(ADDR_RES_FLAGS);
      chk(16'(rv), 16'(e[23:16]));
      rd(ADDR_PWR_CH_REF);
      chk(16'(rv), 16'(rows[i].d3));
    end
    // result registers ignore writes
    wr(ADDR_RESULT_HIGH, 8'hff);
    rd(ADDR_RESULT_HIGH);
    chk(16'(rv), 16'h0001);
    // abort in mid-wakeup restarts with the short wakeup, one pulse only
    wr(ADDR_RES_FLAGS, 8'h00);
    wr(ADDR_MODE_TIMING, 8'h00);
    wr(ADDR_PWR_CH_REF, 8'h80);
    repeat (100) @(negedge clk_sys_in);
    rd(ADDR_PWR_CH_REF);
    chk(16'(rv), 16'h00c0);
    wr(ADDR_PWR_CH_REF, 8'h80);
    wait_irq();
    chk(16'(n), 16'd84);
    quiet(600);
    // mode register write does not start a conversion
    wr(ADDR_MODE_TIMING, 8'h04);
    quiet(500);
    // single step with standby hold: quick restart, then power-down
    wr(ADDR_PWR_CH_REF, 8'h80);
    wait_irq();
    chk(16'(sby), 16'h0001);
    wr(ADDR_PWR_CH_REF, 8'h80);
    wait_irq();
    chk(16'(n), 16'd84);
    repeat (149) @(negedge clk_sys_in);
    chk(16'(sby), 16'h0001);
    repeat (2) @(negedge clk_sys_in);
    chk(16'({sby, pwr}), 16'h0000);
    // longer hold: still standing on its last cycle, gone after it
    wr(ADDR_MODE_TIMING, 8'h08);
    wr(ADDR_PWR_CH_REF, 8'h80);
    wait_irq();
    chk(16'(n), 16'd444);
    repeat (599) @(negedge clk_sys_in);
    chk(16'(sby), 16'h0001);
    repeat (2) @(negedge clk_sys_in);
    chk(16'(sby), 16'h0000);
    // endless standby, phase outputs on the way; a power-low write ends it
    wr(ADDR_MODE_TIMING, 8'h0c);
    wr(ADDR_PWR_CH_REF, 8'h80);
    repeat (382) @(negedge clk_sys_in);
    chk(16'({sw, conv}), 16'h0002);
    repeat (19) @(negedge clk_sys_in);
    chk(16'({sw, conv}), 16'h0001);
    wait_irq();
    chk(16'(n), 16'd43);
    repeat (700) @(negedge clk_sys_in);
    chk(16'(sby), 16'h0001);
    wr(ADDR_PWR_CH_REF, 8'h00);
    chk(16'({sby, pins}), 16'h0000);
    // continuous at the 16 ksps rate code, powered down between samples
    wr(ADDR_MODE_TIMING, 8'h2c);
    wr(ADDR_PWR_CH_REF, 8'h80);
    wait_irq();
    chk(16'(n), 16'd444);
    chk(16'(pwr), 16'h0000);
    wait_irq();
    chk(16'(n), 16'd1562);
    // clearing the power bit stops everything at once
    wr(ADDR_PWR_CH_REF, 8'h00);
    chk(16'({pins, pwr}), 16'h0000);
    quiet(2000);
    // reset in mid-wakeup clears every register again
    wr(ADDR_PWR_CH_REF, 8'h80);
    repeat (50) @(negedge clk_sys_in);
    rst_n_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    chk(16'({pins, pwr, irq}), 16'h0000);
    for (int a = 'hd1; a <= 'hd5; a++) begin
      rd(8'(a));
      chk(16'(rv), 16'h0000);
    end
    results();
  end
endmodule

`default_nettype wire
